/* hw/tlm_top.sv */
// Toner level monitor: agitation sensor timing, supply drive, toner-low and alarm logic.
// Assumes asynchronous sensor and drum pins, a dot pulse from same-clock logic,
// and a classic Wishbone master for the registers.
`include "tlm_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module tlm_top #(
  parameter logic [31:0] TICK_CYCLES = `TLM_TICK_CYCLES,
  parameter logic [31:0] DOTS_PER_SHEET = `TLM_DOTS_PER_SHEET
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // Sensor side
  input wire logic sensor_in,
  input wire logic drum_run_in,
  input wire logic dot_in,
  // Actuators and indications
  output logic supply_roller_out,
  output logic agit_spring_out,
  output logic toner_low_out,
  output logic toner_empty_out,
  output logic sensor_alarm_out,
  output logic irq_out
);

  localparam logic [31:0] DISP_DOTS = `TLM_DISP_SHEETS * DOTS_PER_SHEET;
  localparam logic [31:0] EMPTY_DOTS = `TLM_EMPTY_SHEETS * DOTS_PER_SHEET;

  logic [2:0] sens_sync_q;
  logic [2:0] drum_sync_q;
  logic sens_q;
  logic drum_q;
  logic prev_q;
  tlm_pkg::tlm_phase_t phase_q;
  logic [31:0] tick_cnt_q;
  logic [31:0] dwell_q;
  logic [31:0] last_dwell_q;
  logic [31:0] still_q;
  logic [31:0] dot_cnt_q;
  logic [4:0] low_run_q;
  logic [4:0] high_run_q;
  logic supply_on_q;
  logic started_q;
  logic toner_low_q;
  logic disp_q;
  logic empty_q;
  logic alarm_q;
  logic [31:0] dwell_limit_q;
  logic [31:0] tick_div_q;
  logic [`TLM_NUM_EV-1:0] irq_stat_q;
  logic [`TLM_NUM_EV-1:0] irq_mask_q;
  logic ack_q;
  logic [31:0] dat_q;

  // Pin synchronisers: a change counts once stages two and three agree
  // Sensor chain resets to its idle high level, so no false edge follows reset
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sens_sync_q <= 3'h7;
      drum_sync_q <= 3'h0;
      sens_q <= 1'b1;
      drum_q <= 1'b0;
    end else begin
      sens_sync_q <= {sens_sync_q[1:0], sensor_in};
      drum_sync_q <= {drum_sync_q[1:0], drum_run_in};
      if (sens_sync_q[1] == sens_sync_q[2]) begin
        sens_q <= sens_sync_q[2];
      end
      if (drum_sync_q[1] == drum_sync_q[2]) begin
        drum_q <= drum_sync_q[2];
      end
    end
  end

  // Speed-scaled time base; stopped drum freezes every timer
  wire run_w = drum_q;
  wire tick_w = run_w && (tick_cnt_q >= tick_div_q - 32'h1);
  wire fall_w = run_w && prev_q && !sens_q;
  wire rise_w = run_w && !prev_q && sens_q;
  wire edge_w = fall_w || rise_w;
  wire cyc_w = rise_w && (phase_q == tlm_pkg::TLM_DWELL);
  wire is_low_w = dwell_q >= dwell_limit_q;
  wire cyc_low_w = cyc_w && is_low_w;
  wire cyc_high_w = cyc_w && !is_low_w;
  wire [4:0] low_inc_w = (low_run_q == `TLM_RUN_MAX) ? low_run_q : low_run_q + 5'h01;
  wire [4:0] high_inc_w = (high_run_q == `TLM_RUN_MAX) ? high_run_q : high_run_q + 5'h01;
  wire supply_start_w = cyc_low_w && !supply_on_q && (low_inc_w >= `TLM_SUPPLY_RUN);
  wire low_recog_w = cyc_low_w && started_q && !toner_low_q
    && (low_inc_w == `TLM_LOW_RUN);
  wire full_clear_w = cyc_high_w && toner_low_q && (high_inc_w == `TLM_FULL_RUN);
  wire disp_set_w = toner_low_q && !disp_q && (dot_cnt_q >= DISP_DOTS);
  wire empty_set_w = toner_low_q && !empty_q && (dot_cnt_q >= EMPTY_DOTS);
  wire alarm_set_w = tick_w && !alarm_q && !edge_w
    && (still_q == `TLM_ALARM_TICKS - 32'h1);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tick_cnt_q <= 32'h0;
      prev_q <= 1'b1;
    end else begin
      prev_q <= sens_q;
      if (tick_w) begin
        tick_cnt_q <= 32'h0;
      end else if (run_w) begin
        tick_cnt_q <= tick_cnt_q + 32'h1;
      end
    end
  end

  // Dwell timing at the lowest point (sensor low)
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phase_q <= tlm_pkg::TLM_WAIT_FALL;
      dwell_q <= 32'h0;
      last_dwell_q <= 32'h0;
    end else begin
      case (phase_q)
        tlm_pkg::TLM_WAIT_FALL: begin
          if (fall_w) begin
            phase_q <= tlm_pkg::TLM_DWELL;
            dwell_q <= 32'h0;
          end
        end
        tlm_pkg::TLM_DWELL: begin
          if (rise_w) begin
            phase_q <= tlm_pkg::TLM_WAIT_FALL;
            last_dwell_q <= dwell_q;
          end else if (tick_w && (dwell_q != 32'hFFFF_FFFF)) begin
            dwell_q <= dwell_q + 32'h1;
          end
        end
        default: begin
          phase_q <= tlm_pkg::TLM_WAIT_FALL;
        end
      endcase
    end
  end

  // Run counters, opposite class zeroes a run
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      low_run_q <= 5'h00;
      high_run_q <= 5'h00;
    end else if (cyc_w) begin
      low_run_q <= is_low_w ? low_inc_w : 5'h00;
      high_run_q <= is_low_w ? 5'h00 : high_inc_w;
    end
  end

  // Supply drive and toner-low state
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      supply_on_q <= 1'b0;
      started_q <= 1'b0;
      toner_low_q <= 1'b0;
      disp_q <= 1'b0;
      empty_q <= 1'b0;
      dot_cnt_q <= 32'h0;
    end else begin
      if (supply_start_w) begin
        supply_on_q <= 1'b1;
        started_q <= 1'b1;
      end else if (cyc_high_w) begin
        supply_on_q <= 1'b0;
      end
      if (full_clear_w) begin
        toner_low_q <= 1'b0;
        started_q <= 1'b0;
        disp_q <= 1'b0;
        empty_q <= 1'b0;
        dot_cnt_q <= 32'h0;
      end else begin
        if (low_recog_w) begin
          toner_low_q <= 1'b1;
        end
        if (disp_set_w) begin
          disp_q <= 1'b1;
        end
        if (empty_set_w) begin
          empty_q <= 1'b1;
        end
        if (toner_low_q && dot_in && (dot_cnt_q != 32'hFFFF_FFFF)) begin
          dot_cnt_q <= dot_cnt_q + 32'h1;
        end
      end
    end
  end

  // Sensor alarm: no transition for three cycle periods
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      still_q <= 32'h0;
      alarm_q <= 1'b0;
    end else if (edge_w) begin
      still_q <= 32'h0;
      alarm_q <= 1'b0;
    end else if (tick_w && !alarm_q) begin
      still_q <= still_q + 32'h1;
      alarm_q <= alarm_set_w;
    end
  end

  // Wishbone decode
  wire req_w = wb_cyc_in && wb_stb_in && !ack_q;
  // Writes land at the edge that sees ack, while the request still stands
  wire wr_w = wb_cyc_in && wb_stb_in && wb_we_in && ack_q;
  wire [5:0] word_w = wb_adr_in[7:2];
  wire [31:0] wmask_w = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}},
    {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
  wire wr_limit_w = wr_w && (word_w == `TLM_ADR_DWELL_LIMIT);
  wire wr_div_w = wr_w && (word_w == `TLM_ADR_TICK_DIV);
  wire wr_stat_w = wr_w && (word_w == `TLM_ADR_IRQ_STAT);
  wire wr_mask_w = wr_w && (word_w == `TLM_ADR_IRQ_MASK);
  wire [`TLM_NUM_EV-1:0] ev_w = {alarm_set_w, empty_set_w, disp_set_w,
    low_recog_w, supply_start_w};
  wire [`TLM_NUM_EV-1:0] clr_w = wr_stat_w ? (wb_dat_in[`TLM_NUM_EV-1:0]
    & wmask_w[`TLM_NUM_EV-1:0]) : {`TLM_NUM_EV{1'b0}};
  wire [31:0] status_w = {25'h0, started_q, drum_q, alarm_q, empty_q, disp_q,
    toner_low_q, supply_on_q};
  wire [31:0] rd_w =
    (word_w == `TLM_ADR_DWELL_LIMIT) ? dwell_limit_q :
    (word_w == `TLM_ADR_TICK_DIV) ? tick_div_q :
    (word_w == `TLM_ADR_STATUS) ? status_w :
    (word_w == `TLM_ADR_IRQ_STAT) ? {27'h0, irq_stat_q} :
    (word_w == `TLM_ADR_IRQ_MASK) ? {27'h0, irq_mask_q} :
    (word_w == `TLM_ADR_LAST_DWELL) ? last_dwell_q :
    (word_w == `TLM_ADR_DOT_COUNT) ? dot_cnt_q : 32'h0;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0;
    end else begin
      ack_q <= req_w;
      if (req_w && !wb_we_in) begin
        dat_q <= rd_w;
      end
    end
  end

  // Settings and interrupt registers; a new event beats a clear
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dwell_limit_q <= `TLM_DWELL_RST;
      tick_div_q <= TICK_CYCLES;
      irq_stat_q <= {`TLM_NUM_EV{1'b0}};
      irq_mask_q <= `TLM_MASK_RST;
    end else begin
      if (wr_limit_w) begin
        dwell_limit_q <= (dwell_limit_q & ~wmask_w) | (wb_dat_in & wmask_w);
      end
      if (wr_div_w) begin
        tick_div_q <= (tick_div_q & ~wmask_w) | (wb_dat_in & wmask_w);
      end
      if (wr_mask_w) begin
        irq_mask_q <= (irq_mask_q & ~wmask_w[`TLM_NUM_EV-1:0])
          | (wb_dat_in[`TLM_NUM_EV-1:0] & wmask_w[`TLM_NUM_EV-1:0]);
      end
      irq_stat_q <= (irq_stat_q & ~clr_w) | ev_w;
    end
  end

  assign wb_ack_out = ack_q;
  assign wb_dat_out = dat_q;
  assign supply_roller_out = supply_on_q;
  assign agit_spring_out = supply_on_q;
  assign toner_low_out = disp_q;
  assign toner_empty_out = empty_q;
  assign sensor_alarm_out = alarm_q;
  assign irq_out = |(irq_stat_q & irq_mask_q);

  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_low_cycle;
    cyc_low_w;
  endsequence
  sequence s_high_cycle;
    cyc_high_w;
  endsequence
  sequence s_sensor_edge;
    edge_w;
  endsequence

  a_supply_start_on: assert property (
    s_low_cycle ##0 (low_run_q == 5'h02) |=> supply_roller_out && agit_spring_out)
    else $error("supply not started after three low cycles");
  a_supply_stop_high: assert property (
    s_high_cycle |=> !supply_roller_out && !agit_spring_out)
    else $error("supply not stopped on a high cycle");
  a_low_recog_twenty: assert property (
    s_low_cycle ##0 (started_q && (low_run_q == 5'h13)) |=> toner_low_q)
    else $error("toner low not recognised after twenty low cycles");
  a_low_clear_ten: assert property (
    s_high_cycle ##0 (toner_low_q && (high_run_q == 5'h09)) |=> !toner_low_q)
    else $error("toner low not cleared after ten full cycles");
  a_disp_held_back: assert property (
    $rose(toner_low_out) |-> $past(dot_cnt_q) >= DISP_DOTS && toner_low_q)
    else $error("toner low shown before dot budget");
  a_empty_dots: assert property (
    $rose(toner_empty_out) |-> $past(dot_cnt_q) >= EMPTY_DOTS)
    else $error("toner empty declared early");
  a_alarm_timing: assert property (
    $rose(sensor_alarm_out) |-> $past(still_q) == `TLM_ALARM_TICKS - 32'h1)
    else $error("sensor alarm at wrong time");
  a_drum_freeze: assert property (
    !drum_q |=> $stable(low_run_q) && $stable(high_run_q) && $stable(still_q)
      && $stable(dwell_q))
    else $error("counters moved with drum stopped");
  a_run_zeroed: assert property (
    s_high_cycle |=> low_run_q == 5'h00)
    else $error("low run not zeroed by high cycle");
  a_class_limit: assert property (
    cyc_w && (dwell_q < dwell_limit_q) |=> high_run_q != 5'h00)
    else $error("short dwell not classed high");
  a_class_low: assert property (
    cyc_w && (dwell_q >= dwell_limit_q) |=> low_run_q != 5'h00)
    else $error("long dwell not classed low");
  a_alarm_edge_clear: assert property (
    s_sensor_edge |=> !sensor_alarm_out && (still_q == 32'h0))
    else $error("sensor edge did not clear the alarm timer");
  a_disp_needs_low: assert property (
    toner_low_out |-> toner_low_q)
    else $error("toner low shown without toner low state");

  // Interrupt status: a new event is never lost to a clear
  a_stat_set_wins: assert property (
    |ev_w |=> ((irq_stat_q & $past(ev_w)) == $past(ev_w)))
    else $error("interrupt event lost");
  a_wb_ack_once: assert property (
    wb_cyc_in && wb_stb_in && !ack_q |=> wb_ack_out ##1 !wb_ack_out)
    else $error("ack not a single cycle");

endmodule : tlm_top
`default_nettype wire

/* shared/tlm_defines.svh */
// Constants of the toner level monitor: register map, field positions, counts, times.
// Assumes a 100 MHz system clock and a 32-bit classic Wishbone register bus.
`ifndef TLM_DEFINES_SVH
`define TLM_DEFINES_SVH

// Register word indices (byte address bits 7:2)
`define TLM_ADR_DWELL_LIMIT 6'h00
`define TLM_ADR_TICK_DIV 6'h01
`define TLM_ADR_STATUS 6'h02
`define TLM_ADR_IRQ_STAT 6'h03
`define TLM_ADR_IRQ_MASK 6'h04
`define TLM_ADR_LAST_DWELL 6'h05
`define TLM_ADR_DOT_COUNT 6'h06

// Status and interrupt bit positions
`define TLM_BIT_SUPPLY 0
`define TLM_BIT_LOW 1
`define TLM_BIT_DISP 2
`define TLM_BIT_EMPTY 3
`define TLM_BIT_ALARM 4
`define TLM_BIT_DRUM 5
`define TLM_BIT_STARTED 6
`define TLM_NUM_EV 5

// Reset values
`define TLM_DWELL_RST 32'h0000_01F4
`define TLM_MASK_RST 5'h00

// Consecutive-cycle thresholds
`define TLM_SUPPLY_RUN 5'h03
`define TLM_LOW_RUN 5'h14
`define TLM_FULL_RUN 5'h0A
`define TLM_RUN_MAX 5'h1F

// Timing: one tick is 1 ms at warm-up speed
`define TLM_CLK_NS 10
`define TLM_TICK_NS 1000000
`define TLM_TICK_CYCLES (`TLM_TICK_NS / `TLM_CLK_NS)
`define TLM_ALARM_MS 32'h0000_08FC
`define TLM_ALARM_REPS 32'h0000_0003
`define TLM_ALARM_TICKS (`TLM_ALARM_MS * `TLM_ALARM_REPS)

// Dot budgets in A4 sheets at 5 percent
`define TLM_DISP_SHEETS 32'h0000_00C8
`define TLM_EMPTY_SHEETS 32'h0000_041A
`define TLM_DOTS_PER_SHEET 32'h0001_0000

`endif

/* shared/tlm_pkg.sv */
// Types of the toner level monitor.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package tlm_pkg;
  typedef enum logic [1:0] {
    TLM_WAIT_FALL = 2'h1,
    TLM_DWELL = 2'h2
  } tlm_phase_t;
endpackage : tlm_pkg
`default_nettype wire

/* tb/tlm_agit_model.sv */
// Agitation sensor model: low while the target sits at its lowest point.
// Assumes the caller steps it from the bench clock.
`timescale 1ns/100ps
`default_nettype none
module tlm_agit_model (
  // Clock
  input wire logic clk_in,
  // Sensor pin
  output logic sensor_out
);
  initial sensor_out = 1'b1;

  // One agitation cycle: dwell low, then back high
  task cycle(input int low_n, input int high_n);
    @(posedge clk_in);
    sensor_out <= 1'b0;
    repeat (low_n) @(posedge clk_in);
    sensor_out <= 1'b1;
    repeat (high_n) @(posedge clk_in);
  endtask : cycle
endmodule : tlm_agit_model
`default_nettype wire

/* tb/tlm_top_tb.sv */
// Self-checking bench of the toner level monitor.
// Assumes the design top, its defines header and the sensor model.
`include "tlm_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module tlm_top_tb;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_dat = 32'h0;
  logic [3:0] wb_sel = 4'hF;
  logic [31:0] wb_q;
  logic wb_ack;
  logic sensor;
  logic drum = 1'b0;
  logic dot = 1'b0;
  logic supply, spring, low, empty, alarm, irq;
  logic [31:0] rd;
  int n_errors = 0;
  int compares = 0;

  always #5 clk_in = ~clk_in;

  tlm_top #(.TICK_CYCLES(32'h4), .DOTS_PER_SHEET(32'h1)) dut_u (
    .clk_in(clk_in), .rst_n_in(rst_n_in),
    .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb), .wb_we_in(wb_we), .wb_adr_in(wb_adr),
    .wb_sel_in(wb_sel), .wb_dat_in(wb_dat), .wb_dat_out(wb_q), .wb_ack_out(wb_ack),
    .sensor_in(sensor), .drum_run_in(drum), .dot_in(dot),
    .supply_roller_out(supply), .agit_spring_out(spring), .toner_low_out(low),
    .toner_empty_out(empty), .sensor_alarm_out(alarm), .irq_out(irq));

  tlm_agit_model agit_u (.clk_in(clk_in), .sensor_out(sensor));

  task tally_and_finish;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish

  task chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch t=%0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask : chk

  // Classic single Wishbone cycle, held until ack
  task wb(input logic we, input logic [5:0] w, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= {w, 2'h0};
    wb_dat <= d;
    do begin
      @(posedge clk_in);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_errors++;
      $display("mismatch t=%0t bus ack timeout", $time);
      tally_and_finish;
    end else begin
      rd = wb_q;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we <= 1'b0;
      @(posedge clk_in);
    end
  endtask : wb

  task dots(input int n);
    dot <= 1'b1;
    repeat (n) @(posedge clk_in);
    dot <= 1'b0;
    repeat (4) @(posedge clk_in);
  endtask : dots

  task t_regs;
    wb(1'b0, `TLM_ADR_DWELL_LIMIT, 32'h0); chk(rd, `TLM_DWELL_RST, "dwell rst");
    wb(1'b0, `TLM_ADR_TICK_DIV, 32'h0); chk(rd, 32'h4, "tick rst");
    wb(1'b0, `TLM_ADR_IRQ_MASK, 32'h0); chk(rd, 32'h0, "mask rst");
    wb(1'b1, 6'h3F, 32'hFFFF_FFFF);
    wb(1'b0, 6'h3F, 32'h0); chk(rd, 32'h0, "unmapped");
    wb(1'b1, `TLM_ADR_TICK_DIV, 32'h1);
    wb_sel <= 4'h1;
    wb(1'b1, `TLM_ADR_DWELL_LIMIT, 32'hFFFF_FF14);
    wb_sel <= 4'hF;
    wb(1'b0, `TLM_ADR_DWELL_LIMIT, 32'h0); chk(rd, 32'h114, "dwell lane");
    wb(1'b1, `TLM_ADR_DWELL_LIMIT, 32'h14);
    wb(1'b0, `TLM_ADR_DWELL_LIMIT, 32'h0); chk(rd, 32'h14, "dwell wr");
    drum <= 1'b1;
    repeat (10) @(posedge clk_in);
  endtask : t_regs

  task t_supply;
    repeat (2) agit_u.cycle(30, 20);
    agit_u.cycle(5, 20);
    repeat (2) agit_u.cycle(30, 20);
    chk({31'h0, supply}, 32'h0, "run broken");
    agit_u.cycle(30, 20);
    chk({30'h0, supply, spring}, 32'h3, "supply on");
    wb(1'b0, `TLM_ADR_LAST_DWELL, 32'h0); chk(rd, 32'h1D, "last dwell");
    wb(1'b1, `TLM_ADR_TICK_DIV, 32'h2);
    agit_u.cycle(30, 20);
    chk({30'h0, supply, spring}, 32'h0, "supply off");
    wb(1'b1, `TLM_ADR_TICK_DIV, 32'h1);
  endtask : t_supply

  task t_lowrec;
    repeat (19) agit_u.cycle(30, 20);
    wb(1'b0, `TLM_ADR_STATUS, 32'h0); chk({31'h0, rd[1]}, 32'h0, "low early");
    drum <= 1'b0;
    repeat (10) @(posedge clk_in);
    repeat (2) agit_u.cycle(30, 20);
    drum <= 1'b1;
    repeat (10) @(posedge clk_in);
    wb(1'b0, `TLM_ADR_STATUS, 32'h0); chk({31'h0, rd[1]}, 32'h0, "drum stop");
    agit_u.cycle(30, 20);
    wb(1'b0, `TLM_ADR_STATUS, 32'h0); chk({31'h0, rd[1]}, 32'h1, "low set");
    chk({31'h0, low}, 32'h0, "disp held");
  endtask : t_lowrec

  task t_dots;
    dots(199); chk({31'h0, low}, 32'h0, "disp 199");
    dots(1); chk({31'h0, low}, 32'h1, "disp 200");
    dots(849); chk({31'h0, empty}, 32'h0, "empty 1049");
    dots(1); chk({31'h0, empty}, 32'h1, "empty 1050");
    wb(1'b0, `TLM_ADR_DOT_COUNT, 32'h0); chk(rd, 32'h41A, "dot count");
  endtask : t_dots

  task t_irq;
    wb(1'b1, `TLM_ADR_STATUS, 32'h0);
    wb(1'b0, `TLM_ADR_STATUS, 32'h0); chk(rd, 32'h6F, "status");
    chk({31'h0, irq}, 32'h0, "irq masked");
    wb(1'b1, `TLM_ADR_IRQ_MASK, 32'h8);
    chk({31'h0, irq}, 32'h1, "irq empty");
    wb(1'b1, `TLM_ADR_IRQ_STAT, 32'h8);
    chk({31'h0, irq}, 32'h0, "irq clr");
    wb(1'b0, `TLM_ADR_IRQ_STAT, 32'h0); chk({31'h0, rd[3]}, 32'h0, "w1c");
    wb(1'b1, `TLM_ADR_IRQ_MASK, 32'h10);
  endtask : t_irq

  task t_full;
    repeat (9) agit_u.cycle(5, 20);
    chk({31'h0, low}, 32'h1, "full 9");
    agit_u.cycle(5, 20);
    chk({29'h0, low, empty, supply}, 32'h0, "full 10");
  endtask : t_full

  task t_alarm;
    repeat (6840) @(posedge clk_in);
    chk({31'h0, alarm}, 32'h0, "alarm early");
    repeat (80) @(posedge clk_in);
    chk({30'h0, alarm, irq}, 32'h3, "alarm on");
    agit_u.cycle(5, 20);
    chk({31'h0, alarm}, 32'h0, "alarm off");
  endtask : t_alarm

  initial begin
    repeat (8) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    t_regs;
    t_supply;
    t_lowrec;
    t_dots;
    t_irq;
    t_full;
    t_alarm;
    tally_and_finish;
  end
endmodule : tlm_top_tb
`default_nettype wire
